// >>> rtl/adc_sched_pkg.sv
// Shared constants and carrier types for the conversion scheduler
package adc_sched_pkg;

    // Clock and timing figures, each in its own unit
    localparam int CLK_PERIOD_NS = 20;
    localparam int AUTOCYCLE_PERIOD_US = 50;
    localparam int TEMP_PERIOD_MS = 5;
    localparam int RESET_PULSE_MAX_NS = 100;

    // Cycle counts derived from the figures above
    localparam int AUTOCYCLE_CYC = (AUTOCYCLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int TEMP_PERIOD_CYC = (TEMP_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_MAX_CYC = RESET_PULSE_MAX_NS / CLK_PERIOD_NS;

    // Widths of the result codes and counters
    localparam int CODE_W = 12;
    localparam int CHAN_W = 3;
    localparam int NUM_CHAN = 8;
    localparam int TEMP_CNT_W = 24;

    // Command word field positions (MSB first on the wire)
    localparam int CMD_CHAN_MSB = 15;
    localparam int CMD_CHAN_LSB = 8;
    localparam int CMD_TEMP_EN_POS = 7;
    localparam int CMD_EXTERNAL_REFERENCE_SELECT_POS = 5;
    localparam int CMD_AUTOCYCLE_POS = 1;

    // Command register reset value: every bit clear
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // Command register layout, bit 15 down to bit 0
    typedef struct packed {
        logic [7:0] channel_mask;
        logic temperature_channel_enable;
        logic spare6;
        logic external_reference_select;
        logic [2:0] spare4_2;
        logic autocycle_mode;
        logic spare0;
    } command_type;

    // Voltage result: channel tag and unsigned straight-binary code
    typedef struct packed {
        logic [CHAN_W-1:0] channel;
        logic [CODE_W-1:0] code;
    } voltage_result_type;

endpackage

// >>> rtl/adc_temp_conversion_scheduler.sv
// Power sequencing, conversion scheduling and temperature averaging
`timescale 1ns/1ns

// Contract
// - Start in partial power-down and stay there whenever not converting.
// - Power up fully before each conversion, drop back when it finishes.
// - In command mode the write-address phase or read start triggers wake and conversion.
// - In autocycle mode convert once every 50 us without host action.
// - Serial reads and writes are accepted even in partial power-down.
// - Voltage results are unsigned binary, temperature results two's complement.
// - Codes are 12 bits, one count per reference/4096.
// - Integration done automatically requests a temperature conversion.
// - In command mode a running voltage conversion finishes before temperature starts.
// - With no voltage conversions, temperature converts every 5 ms.
// - In autocycle a pending temperature slots into the sequence, at once if idle.
// - Latest temperature conversion is held in its own result register.
// - Temperature channel and averaging run only while the enable bit is set.
// - Average becomes seven eighths old average plus one eighth new result.
// - First result after enabling is stored raw, without averaging.
// - Temperature is 12-bit two's complement, 0.25 degrees per count.
// - Temperature code spans -512 to +511.75 degrees.
// - Internal reference after reset; command bit selects external reference.
// - Short low pulse on powerdown_reset_n resets all registers including command.
// - Holding powerdown_reset_n low beyond 100 ns enters full power-down.
// - Command register is all zero after power-up or reset.
module adc_temp_conversion_scheduler #(
    parameter int TEMP_PERIOD_CYC = adc_sched_pkg::TEMP_PERIOD_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_powerdown_reset_n,
    input wire logic i_cmd_write,
    input wire adc_sched_pkg::command_type i_cmd_data,
    input wire logic i_write_address,
    input wire logic i_read_start,
    input wire logic i_integration_done,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_code,
    output logic o_power_full,
    output logic o_full_powerdown,
    output logic o_conv_start,
    output logic o_conv_temp,
    output logic [2:0] o_conv_channel,
    output logic o_ref_external,
    output adc_sched_pkg::voltage_result_type o_voltage_result,
    output logic [11:0] o_temp_result,
    output logic [11:0] o_temp_average,
    output logic o_temp_valid
);

    typedef enum logic [1:0] {st_sleep, st_wake, st_convert} state_type;

    state_type state;
    state_type next_state;
    adc_sched_pkg::command_type cmd;
    logic pd_sync1, pd_sync2, pd_prev;
    logic [3:0] pd_low_cnt;
    logic integ_sync1, integ_sync2, integ_prev;
    logic [11:0] auto_cnt;
    logic [adc_sched_pkg::TEMP_CNT_W-1:0] temp_cnt;
    logic volt_pending, temp_pending;
    logic conv_is_temp;
    logic [2:0] cur_channel;
    logic [2:0] next_channel;
    logic next_channel_ok;

    // Pin qualification: a short low pulse resets, a long one powers down
    wire soft_clear = pd_sync2 && !pd_prev &&
        (pd_low_cnt <= 4'(adc_sched_pkg::RESET_PULSE_MAX_CYC));
    wire long_low = pd_low_cnt > 4'(adc_sched_pkg::RESET_PULSE_MAX_CYC);
    wire integ_edge = integ_sync2 && !integ_prev;
    wire temp_on = cmd.temperature_channel_enable;
    wire autocycle = cmd.autocycle_mode;

    // Timer ticks and request sources
    wire auto_tick = autocycle && (auto_cnt == 12'(adc_sched_pkg::AUTOCYCLE_CYC - 1));
    wire temp_tick = temp_on &&
        (temp_cnt == adc_sched_pkg::TEMP_CNT_W'(TEMP_PERIOD_CYC - 1));
    wire host_trigger = !autocycle && (i_write_address || i_read_start);
    wire volt_req = (host_trigger || auto_tick) && (cmd.channel_mask != 8'h00);
    wire temp_req = temp_on && (integ_edge || temp_tick);

    // Arbitration when asleep: command mode serves the host first,
    // autocycle slots a waiting temperature conversion before the next channel
    wire pick_temp = temp_pending && (autocycle || !volt_pending);
    wire pick_volt = volt_pending && !pick_temp;
    wire sleep_go = (state == st_sleep) && !long_low && (pick_temp || pick_volt);
    wire conv_end = (state == st_convert) && i_conv_done;
    wire temp_end = conv_end && conv_is_temp;
    wire volt_start = sleep_go && pick_volt;

    // Averaging in 15-bit signed arithmetic so 7x the code cannot overflow
    wire logic signed [14:0] avg_prev_x = {{3{o_temp_average[11]}}, o_temp_average};
    wire logic signed [14:0] new_x = {{3{i_conv_code[11]}}, i_conv_code};
    wire logic signed [14:0] avg_sum = 15'(avg_prev_x * 15'sd7) + new_x;
    wire logic [11:0] avg_calc = o_temp_valid ? avg_sum[14:3] : i_conv_code;

    // Next enabled channel after the current one, wrapping round
    always_comb begin
        next_channel = cur_channel;
        next_channel_ok = 1'b0;
        for (int k = 7; k >= 1; k--) begin
            if (cmd.channel_mask[3'(cur_channel + 3'(k))]) begin
                next_channel = 3'(cur_channel + 3'(k));
                next_channel_ok = 1'b1;
            end
        end
        if (!next_channel_ok && cmd.channel_mask[cur_channel]) begin
            next_channel_ok = 1'b1;
        end
    end

    // Power state sequence: sleep is partial power-down
    always_comb begin
        next_state = state;
        case (state)
            st_sleep: begin
                if (sleep_go) begin
                    next_state = st_wake;
                end
            end
            st_wake: begin
                next_state = st_convert;
            end
            st_convert: begin
                if (i_conv_done) begin
                    next_state = st_sleep;
                end
            end
            default: begin
                next_state = st_sleep;
            end
        endcase
        // A long low on the pin abandons any conversion so the core powers down at once
        if (long_low) begin
            next_state = st_sleep;
        end
    end

    // Two-flop synchronisers for the reset pin and integration flag
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pd_sync1 <= 1'b1;
            pd_sync2 <= 1'b1;
            pd_prev <= 1'b1;
            integ_sync1 <= 1'b0;
            integ_sync2 <= 1'b0;
            integ_prev <= 1'b0;
        end else begin
            pd_sync1 <= i_powerdown_reset_n;
            pd_sync2 <= pd_sync1;
            pd_prev <= pd_sync2;
            integ_sync1 <= i_integration_done;
            integ_sync2 <= integ_sync1;
            integ_prev <= integ_sync2;
        end
    end

    // Low-time meter; saturates so a long hold keeps power-down asserted
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pd_low_cnt <= 4'h0;
            o_full_powerdown <= 1'b0;
        end else begin
            if (pd_sync2) begin
                pd_low_cnt <= 4'h0;
            end else if (pd_low_cnt != 4'hf) begin
                pd_low_cnt <= pd_low_cnt + 4'h1;
            end
            o_full_powerdown <= long_low && !pd_sync2;
        end
    end

    // Command register: cleared by either reset path
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd <= adc_sched_pkg::CMD_RESET;
            o_ref_external <= 1'b0;
        end else if (soft_clear) begin
            cmd <= adc_sched_pkg::CMD_RESET;
            o_ref_external <= 1'b0;
        end else begin
            if (i_cmd_write) begin
                cmd <= i_cmd_data;
            end
            o_ref_external <= cmd.external_reference_select;
        end
    end

    // Period counters; the temperature one restarts on every voltage start
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            auto_cnt <= 12'h000;
            temp_cnt <= '0;
        end else if (soft_clear || long_low) begin
            auto_cnt <= 12'h000;
            temp_cnt <= '0;
        end else begin
            auto_cnt <= (!autocycle || auto_tick) ? 12'h000 : auto_cnt + 12'h001;
            temp_cnt <= (!temp_on || temp_tick || volt_start) ? '0 : temp_cnt + 1'b1;
        end
    end

    // Pending requests; a new request in the clearing cycle wins
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            volt_pending <= 1'b0;
            temp_pending <= 1'b0;
        end else if (soft_clear || long_low) begin
            volt_pending <= 1'b0;
            temp_pending <= 1'b0;
        end else begin
            volt_pending <= volt_req || (volt_pending && !volt_start && cmd.channel_mask != 8'h00);
            temp_pending <= temp_req ||
                (temp_pending && temp_on && !(sleep_go && pick_temp));
        end
    end

    // Sequencer and converter handshake; all outputs registered
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= st_sleep;
            o_power_full <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_temp <= 1'b0;
            o_conv_channel <= 3'h0;
            conv_is_temp <= 1'b0;
            cur_channel <= 3'h7;
        end else if (soft_clear) begin
            state <= st_sleep;
            o_power_full <= 1'b0;
            o_conv_start <= 1'b0;
            o_conv_temp <= 1'b0;
            o_conv_channel <= 3'h0;
            conv_is_temp <= 1'b0;
            cur_channel <= 3'h7;
        end else begin
            state <= next_state;
            o_power_full <= (next_state != st_sleep);
            o_conv_start <= (state == st_wake) && (next_state == st_convert);
            if (sleep_go) begin
                conv_is_temp <= pick_temp;
                o_conv_temp <= pick_temp;
                if (pick_volt) begin
                    cur_channel <= next_channel;
                    o_conv_channel <= next_channel;
                end
            end
        end
    end

    // Result registers; conversions in flight when a reset hits are dropped
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_voltage_result <= '0;
            o_temp_result <= 12'h000;
            o_temp_average <= 12'h000;
            o_temp_valid <= 1'b0;
        end else if (soft_clear) begin
            o_voltage_result <= '0;
            o_temp_result <= 12'h000;
            o_temp_average <= 12'h000;
            o_temp_valid <= 1'b0;
        end else begin
            if (conv_end && !conv_is_temp) begin
                o_voltage_result <= '{channel: o_conv_channel,
                    code: i_conv_code};
            end
            if (!temp_on) begin
                o_temp_valid <= 1'b0;
            end else if (temp_end) begin
                o_temp_result <= i_conv_code;
                o_temp_average <= avg_calc;
                o_temp_valid <= 1'b1;
            end
        end
    end

    // Checks on sequencing, timing and result arithmetic
    sleep_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state == st_sleep && !sleep_go) |=> !o_power_full)
        else $error("awake while idle");
    start_powered_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_conv_start |-> o_power_full ##1 (o_power_full && !o_conv_start))
        else $error("conversion started without full power");
    done_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (conv_end && !soft_clear) |=> !o_power_full)
        else $error("power held after conversion");
    host_wake_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (host_trigger && cmd.channel_mask != 8'h00 && state == st_sleep && !temp_pending
         && !long_low && !soft_clear && !i_cmd_write && !pd_sync2 == 1'b0)
        |-> ##3 (o_conv_start && !o_conv_temp))
        else $error("host trigger did not start a conversion");
    auto_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (auto_tick && cmd.channel_mask != 8'h00 && !soft_clear && !long_low) |=> volt_pending)
        else $error("autocycle tick lost");
    temp_store_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (temp_end && temp_on && !soft_clear) |=> (o_temp_result == $past(i_conv_code)))
        else $error("temperature result not stored");
    avg_math_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (temp_end && temp_on && o_temp_valid && !soft_clear)
        |=> (o_temp_average == $past(avg_sum[14:3])))
        else $error("average update wrong");
    first_raw_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (temp_end && temp_on && !o_temp_valid && !soft_clear)
        |=> (o_temp_average == o_temp_result) && o_temp_valid)
        else $error("first temperature result averaged");
    temp_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !temp_on |=> !temp_pending)
        else $error("temperature pending while disabled");
    ref_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_cmd_write && !soft_clear) |-> ##2
        (o_ref_external == $past(i_cmd_data.external_reference_select, 2)))
        else $error("reference select not applied");
    short_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        soft_clear |=> (cmd == adc_sched_pkg::CMD_RESET) && !o_temp_valid)
        else $error("short pulse did not reset");
    long_pd_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (long_low && !pd_sync2) |=> (o_full_powerdown && state == st_sleep))
        else $error("long pulse did not power down");

    temp_conv_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) temp_end && o_temp_valid);
    auto_conv_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) autocycle && volt_start);
    soft_reset_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) soft_clear);
    full_pd_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) o_full_powerdown);

endmodule

// >>> tb/converter_model.sv
// Behavioural converter that answers each conversion start after a set latency
`timescale 1ns/1ns
module converter_model (
    input wire logic i_clk_sys,
    input wire logic i_conv_start,
    input wire logic i_conv_temp,
    input wire logic [7:0] i_latency,
    input wire logic [11:0] i_volt_code,
    input wire logic [11:0] i_temp_code,
    output logic o_conv_done,
    output logic [11:0] o_conv_code
);
    logic is_temp;

    initial begin
        o_conv_done = 1'b0;
        o_conv_code = 12'hA5A;
    end

    // The code is valid only with the done pulse; afterwards it flips so nothing stale passes
    always begin
        @(posedge i_clk_sys);
        if (i_conv_start === 1'b1) begin
            is_temp = i_conv_temp;
            repeat (i_latency) @(posedge i_clk_sys);
            #2;
            o_conv_code = is_temp ? i_temp_code : i_volt_code;
            o_conv_done = 1'b1;
            @(posedge i_clk_sys);
            #2;
            o_conv_done = 1'b0;
            o_conv_code = ~o_conv_code;
        end
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the conversion scheduler
`timescale 1ns/1ns
module tb;
    logic i_clk_sys;
    logic i_nrst;
    logic pin_n;
    logic cmd_write;
    adc_sched_pkg::command_type cmd_data;
    logic write_address;
    logic read_start;
    logic integration_done;
    logic conv_done;
    logic [11:0] conv_code;
    logic power_full;
    logic full_powerdown;
    logic conv_start;
    logic conv_temp;
    logic [2:0] conv_channel;
    logic ref_external;
    adc_sched_pkg::voltage_result_type voltage_result;
    logic [11:0] temp_result;
    logic [11:0] temp_average;
    logic temp_valid;
    logic [7:0] latency;
    logic [11:0] volt_code;
    logic [11:0] temp_code;
    int mismatches;
    int samples_checked;
    int cnt;
    time t0;

    adc_temp_conversion_scheduler #(.TEMP_PERIOD_CYC(400)) u_adc_temp_conversion_scheduler (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_powerdown_reset_n(pin_n),
        .i_cmd_write(cmd_write), .i_cmd_data(cmd_data), .i_write_address(write_address),
        .i_read_start(read_start), .i_integration_done(integration_done),
        .i_conv_done(conv_done), .i_conv_code(conv_code), .o_power_full(power_full),
        .o_full_powerdown(full_powerdown), .o_conv_start(conv_start),
        .o_conv_temp(conv_temp), .o_conv_channel(conv_channel),
        .o_ref_external(ref_external), .o_voltage_result(voltage_result),
        .o_temp_result(temp_result), .o_temp_average(temp_average),
        .o_temp_valid(temp_valid));

    converter_model u_converter_model (
        .i_clk_sys(i_clk_sys), .i_conv_start(conv_start), .i_conv_temp(conv_temp),
        .i_latency(latency), .i_volt_code(volt_code), .i_temp_code(temp_code),
        .o_conv_done(conv_done), .o_conv_code(conv_code));

    // 50 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #2;
    endtask

    task automatic check_flag(input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic check_code(input logic [14:0] exp, input logic [14:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic write_cmd(input logic [7:0] mask, input logic t, input logic e, input logic a);
        cmd_data = '0;
        cmd_data.channel_mask = mask;
        cmd_data.temperature_channel_enable = t;
        cmd_data.external_reference_select = e;
        cmd_data.autocycle_mode = a;
        cmd_write = 1'b1;
        step(1);
        cmd_write = 1'b0;
    endtask

    task automatic trigger(input logic rd);
        read_start = rd;
        write_address = ~rd;
        step(1);
        read_start = 1'b0;
        write_address = 1'b0;
    endtask

    // Sensor flag stays high three clocks so the two-flop sampler sees it
    task automatic integ;
        integration_done = 1'b1;
        step(3);
        integration_done = 1'b0;
    endtask

    task automatic wait_start(input int limit);
        cnt = 0;
        while (conv_start !== 1'b1 && cnt < limit) begin
            step(1);
            cnt++;
        end
    endtask

    task automatic finish_conv;
        cnt = 0;
        while (power_full === 1'b1 && cnt < 100) begin
            step(1);
            cnt++;
        end
    endtask

    task automatic t_command;
        write_cmd(8'h06, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            volt_code = (i == 0) ? 12'hFFF : ((i == 1) ? 12'h000 : 12'h800);
            trigger(i[0]);
            wait_start(10);
            // Start is seen two polls after the taken edge, so it is sampled on the third edge
            check_code(15'h0002, 15'(cnt));
            check_flag(1'b1, power_full);
            finish_conv();
            check_flag(1'b0, power_full);
            check_code({(i == 1) ? 3'h2 : 3'h1, volt_code}, voltage_result);
        end
    endtask

    task automatic t_external_reference_select;
        write_cmd(8'h06, 1'b0, 1'b1, 1'b0);
        check_flag(1'b0, power_full);
        check_flag(1'b0, ref_external);
        step(1);
        check_flag(1'b1, ref_external);
    endtask

    task automatic t_temp;
        logic [11:0] avg;
        write_cmd(8'h00, 1'b1, 1'b1, 1'b0);
        temp_code = 12'h064;
        integ();
        wait_start(12);
        check_flag(1'b1, conv_temp);
        finish_conv();
        check_code(15'h0064, {3'h0, temp_result});
        check_code(15'h0064, {3'h0, temp_average});
        check_flag(1'b1, temp_valid);
        temp_code = 12'hF60;
        avg = 12'((7 * 100 + $signed(temp_code)) >>> 3);
        integ();
        wait_start(12);
        finish_conv();
        check_code({3'h0, temp_code}, {3'h0, temp_result});
        check_code({3'h0, avg}, {3'h0, temp_average});
    endtask

    // Temperature request arrives mid voltage conversion in command mode
    task automatic t_temp_wait;
        write_cmd(8'h02, 1'b1, 1'b1, 1'b0);
        latency = 8'h14;
        trigger(1'b0);
        wait_start(10);
        check_flag(1'b0, conv_temp);
        integ();
        check_flag(1'b1, power_full);
        finish_conv();
        wait_start(10);
        check_flag(1'b1, conv_temp);
        finish_conv();
        latency = 8'h08;
    endtask

    task automatic t_period;
        write_cmd(8'h00, 1'b1, 1'b1, 1'b0);
        wait_start(450);
        t0 = $time;
        step(1);
        wait_start(450);
        check_flag(1'b1, conv_temp);
        check_flag(1'b1, ($time - t0) / 20 >= 398 && ($time - t0) / 20 <= 410);
        finish_conv();
        write_cmd(8'h00, 1'b0, 1'b1, 1'b0);
        step(3);
        check_flag(1'b0, temp_valid);
        integ();
        wait_start(12);
        check_flag(1'b0, conv_start);
    endtask

    task automatic t_auto;
        write_cmd(8'h01, 1'b0, 1'b1, 1'b1);
        wait_start(2600);
        t0 = $time;
        check_code(15'h0000, {12'h000, conv_channel});
        step(1200);
        check_flag(1'b0, power_full);
        wait_start(2600);
        check_code(15'(adc_sched_pkg::AUTOCYCLE_CYC), 15'(($time - t0) / 20));
        finish_conv();
        write_cmd(8'h01, 1'b1, 1'b1, 1'b1);
        integ();
        wait_start(12);
        check_flag(1'b1, conv_temp);
        finish_conv();
    endtask

    // The pin is only ever moved on purpose and otherwise held high
    task automatic t_pin;
        pin_n = 1'b0;
        step(3);
        pin_n = 1'b1;
        step(8);
        check_flag(1'b0, ref_external);
        check_flag(1'b0, temp_valid);
        check_flag(1'b0, full_powerdown);
        write_cmd(8'h01, 1'b0, 1'b1, 1'b0);
        step(2);
        pin_n = 1'b0;
        step(10);
        check_flag(1'b1, full_powerdown);
        trigger(1'b0);
        wait_start(6);
        check_flag(1'b0, conv_start);
        pin_n = 1'b1;
        step(8);
        check_flag(1'b0, full_powerdown);
        check_flag(1'b1, ref_external);
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Whole run is about 6000 cycles; allow generous headroom
    initial begin
        #(20 * 20000);
        mismatches++;
        final_report();
    end

    initial begin
        i_nrst = 1'b0;
        pin_n = 1'b1;
        cmd_write = 1'b0;
        cmd_data = '0;
        write_address = 1'b0;
        read_start = 1'b0;
        integration_done = 1'b0;
        latency = 8'h08;
        volt_code = 12'h000;
        temp_code = 12'h000;
        mismatches = 0;
        samples_checked = 0;
        step(10);
        i_nrst = 1'b1;
        step(1);
        check_flag(1'b0, power_full);
        check_flag(1'b0, ref_external);
        check_flag(1'b0, temp_valid);
        t_command();
        t_external_reference_select();
        t_temp();
        t_temp_wait();
        t_period();
        t_auto();
        t_pin();
        final_report();
    end
endmodule
